// ### common/stp_pkg.sv
`default_nettype none
package stp_pkg;

    // ------------------------------------------------------------
    // Pin functions and output sources
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        STP_FN_SYNC_ON,
        STP_FN_INPUT,
        STP_FN_OUTPUT
    } stp_func_e;

    typedef enum logic [1:0] {
        STP_SRC_ONE,
        STP_SRC_ZERO,
        STP_SRC_PWM
    } stp_src_e;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_HZ = 40000000;
    localparam int PULSE_MIN_NS = 30000;
    localparam int CLK_PERIOD_NS = 1000000000 / CLK_HZ;
    // Least time: round up
    localparam int PULSE_MIN_CYC = (PULSE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Emitted pulse keeps the low level for twice the least width
    localparam int PULSE_OUT_CYC = 2 * PULSE_MIN_CYC;
    // Read-back of our own pulse is blanked this long after it ends
    localparam int BLANK_CYC = PULSE_MIN_CYC;
    localparam int CNT_W = 16;

    // ------------------------------------------------------------
    // PWM settings
    // ------------------------------------------------------------
    localparam int PWM_W = 16;
    localparam logic [PWM_W-1:0] PWM_PERIOD_RST = 16'h0fa0;
    localparam logic [PWM_W-1:0] PWM_HIGH_RST = 16'h07d0;

endpackage
`default_nettype wire

// ### rtl/stp_pwm.sv
`timescale 1ns/100ps
`default_nettype none

module stp_pwm (
    // Clock and reset
    input wire logic clk,
    input wire logic srst,
    // Settings
    input wire logic enable,
    input wire logic [stp_pkg::PWM_W-1:0] period,
    input wire logic [stp_pkg::PWM_W-1:0] high_time,
    // Waveform
    output logic wave
);

    typedef struct packed {
        logic [stp_pkg::PWM_W-1:0] cnt;
        logic wave;
    } stp_pwm_s;

    stp_pwm_s st_r;
    stp_pwm_s st_nxt;

    always_comb begin
        st_nxt = st_r;
        if (!enable || st_r.cnt + 16'h0001 >= period) begin
            st_nxt.cnt = '0;
        end else begin
            st_nxt.cnt = st_r.cnt + 16'h0001;
        end
        st_nxt.wave = enable && (st_nxt.cnt < high_time);
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign wave = st_r.wave;

endmodule

`default_nettype wire

// ### rtl/stp_sync_on.sv
// Overview of operation
// R01: One polarity setting inverts both the sensed input and the driven output of the pin.
// R02: After reset the pin takes the synchronized turn-on function, working both ways.
// R03: As a plain input the pin's level is sampled and reported.
// R04: As an output the pin drives a constant one, a constant zero or a PWM waveform.
// R05: Constant one drives the pin low normally and high when inverted.
// R06: Constant zero drives the pin high normally and low when inverted.
// R07: PWM frequency and duty are separate settings.
// R08: The far instrument holds each sync pulse low for at least 30 us.
// R09: A local off-to-on command emits a pulse on the pin in the turn-on function.
// R10: A pulse received while the output is already on is ignored.
// R11: A valid pulse received while the output is off turns the output on.
// R12: The pin input is synchronized and a pulse counts only after its active low lasted the least width.
// R13: Our own emitted pulse read back on the pin is not taken as a request.
`timescale 1ns/100ps
`default_nettype none

module stp_sync_on (
    // Clock and reset
    input wire logic clk,
    input wire logic srst,
    // Configuration
    input wire logic invert,
    input wire logic [1:0] func_sel,
    input wire logic [1:0] out_src,
    input wire logic [stp_pkg::PWM_W-1:0] pwm_period,
    input wire logic [stp_pkg::PWM_W-1:0] pwm_high,
    // Output-enable state
    input wire logic local_on_req,
    input wire logic local_off_req,
    output logic out_on,
    output logic remote_on_pulse,
    // Plain input level
    output logic in_level,
    // Pin, open drain style
    input wire logic pin_i,
    output logic pin_o,
    output logic pin_oe_n
);

    typedef struct packed {
        logic sync1;
        logic sync2;
        logic [stp_pkg::CNT_W-1:0] low_cnt;
        logic armed;
        logic [stp_pkg::CNT_W-1:0] tx_cnt;
        logic [stp_pkg::CNT_W-1:0] blank_cnt;
        logic on;
        logic remote;
        logic level;
        logic pin_o;
        logic pin_oe_n;
    } stp_state_s;

    stp_state_s st_r;
    stp_state_s st_nxt;
    logic pwm_wave;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic pol(input logic v, input logic inv);
        pol = v ^ inv;
    endfunction

    // ------------------------------------------------------------
    // PWM source
    // ------------------------------------------------------------
    stp_pwm u_pwm (
        .clk(clk),
        .srst(srst),
        .enable(func_sel == 2'(stp_pkg::STP_FN_OUTPUT) && out_src == 2'(stp_pkg::STP_SRC_PWM)),
        .period(pwm_period),
        .high_time(pwm_high),
        .wave(pwm_wave)
    );

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        logic active;
        logic valid;
        logic own;
        logic fire;
        active = 1'b0;
        valid = 1'b0;
        own = 1'b0;
        fire = 1'b0;
        st_nxt = st_r;
        st_nxt.remote = 1'b0;

        // Input synchroniser; only sync2 is examined
        st_nxt.sync1 = pin_i; // R12
        st_nxt.sync2 = st_r.sync1; // R12
        // Active pulse level is low, high when inverted
        active = !pol(st_r.sync2, invert); // R01

        // Own pulse and its tail are blanked from the receiver
        own = (st_r.tx_cnt != '0) || (st_r.blank_cnt != '0); // R13

        if (!active || own) begin
            st_nxt.low_cnt = '0;
            st_nxt.armed = !active;
        end else if (st_r.low_cnt < 16'(stp_pkg::PULSE_MIN_CYC)) begin
            st_nxt.low_cnt = st_r.low_cnt + 16'h0001; // R12
        end
        // One acceptance per pulse, once the least width is met
        if (st_r.armed && active && !own && st_r.low_cnt == 16'(stp_pkg::PULSE_MIN_CYC) - 16'h0001) begin
            valid = 1'b1; // R12
            st_nxt.armed = 1'b0;
        end

        // Output-enable state
        if (local_off_req) begin
            st_nxt.on = 1'b0;
        end else if (local_on_req && !st_r.on) begin
            st_nxt.on = 1'b1;
            fire = (func_sel == 2'(stp_pkg::STP_FN_SYNC_ON)); // R09
        end else if (valid && func_sel == 2'(stp_pkg::STP_FN_SYNC_ON) && !st_r.on) begin // R10
            st_nxt.on = 1'b1; // R11
            st_nxt.remote = 1'b1;
        end

        // Transmit pulse timer and blanking tail
        if (fire) begin
            st_nxt.tx_cnt = 16'(stp_pkg::PULSE_OUT_CYC);
        end else if (st_r.tx_cnt != '0) begin
            st_nxt.tx_cnt = st_r.tx_cnt - 16'h0001;
            if (st_r.tx_cnt == 16'h0001) begin
                st_nxt.blank_cnt = 16'(stp_pkg::BLANK_CYC); // R13
            end
        end else if (st_r.blank_cnt != '0) begin
            st_nxt.blank_cnt = st_r.blank_cnt - 16'h0001;
        end
        if (func_sel != 2'(stp_pkg::STP_FN_SYNC_ON)) begin
            st_nxt.tx_cnt = '0;
        end

        // Plain input level, polarity adjusted
        st_nxt.level = (func_sel == 2'(stp_pkg::STP_FN_INPUT)) ? pol(st_r.sync2, invert) : 1'b0; // R03

        // Pin drive
        unique case (func_sel)
            2'(stp_pkg::STP_FN_SYNC_ON): begin
                // Pulse is low on the line normally, high when inverted
                st_nxt.pin_o = pol(1'b0, invert); // R02
                st_nxt.pin_oe_n = (st_nxt.tx_cnt == '0); // R09
            end
            2'(stp_pkg::STP_FN_OUTPUT): begin
                st_nxt.pin_oe_n = 1'b0; // R04
                unique case (out_src)
                    2'(stp_pkg::STP_SRC_ONE): st_nxt.pin_o = pol(1'b0, invert); // R05
                    2'(stp_pkg::STP_SRC_ZERO): st_nxt.pin_o = pol(1'b1, invert); // R06
                    // A high PWM phase is a logic one, driven like the constant one
                    default: st_nxt.pin_o = pol(!pwm_wave, invert); // R07
                endcase
            end
            default: begin
                st_nxt.pin_o = 1'b1;
                st_nxt.pin_oe_n = 1'b1;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            st_r <= '0;
            st_r.sync1 <= 1'b1;
            st_r.sync2 <= 1'b1;
            st_r.pin_o <= 1'b1;
            st_r.pin_oe_n <= 1'b1;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign out_on = st_r.on;
    assign remote_on_pulse = st_r.remote;
    assign in_level = st_r.level;
    assign pin_o = st_r.pin_o;
    assign pin_oe_n = st_r.pin_oe_n;

endmodule

`default_nettype wire

// ### verification/stp_sync_on_sva.sv
`timescale 1ns/100ps
`default_nettype none
module stp_sync_on_sva (
    // Clock and reset
    input wire logic clk,
    input wire logic srst,
    // Watched ports
    input wire logic invert,
    input wire logic [1:0] func_sel,
    input wire logic [1:0] out_src,
    input wire logic local_on_req,
    input wire logic local_off_req,
    input wire logic out_on,
    input wire logic remote_on_pulse,
    input wire logic in_level,
    input wire logic pin_i,
    input wire logic pin_o,
    input wire logic pin_oe_n
);
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (srst);
    a_local_emit: assert property (func_sel == 2'h0 && !out_on && local_on_req && !local_off_req
        |=> out_on && !pin_oe_n && pin_o == $past(invert)) else $error("no pulse on local turn-on");
    a_one_low: assert property (func_sel == 2'h2 && out_src == 2'h0 ##1 func_sel == 2'h2 && out_src == 2'h0
        |-> !pin_oe_n && pin_o == $past(invert)) else $error("constant one level wrong");
    a_zero_high: assert property (func_sel == 2'h2 && out_src == 2'h1 ##1 func_sel == 2'h2 && out_src == 2'h1
        |-> !pin_oe_n && pin_o == !$past(invert)) else $error("constant zero level wrong");
    a_input_gate: assert property ($past(func_sel) != 2'h1 |-> !in_level) else $error("level outside input mode");
    a_on_holds: assert property (out_on && !local_off_req |=> out_on && !remote_on_pulse)
        else $error("pulse taken while on");
    a_remote_once: assert property (remote_on_pulse |-> (out_on && !$past(out_on)) ##1 !remote_on_pulse)
        else $error("remote turn-on malformed");
    a_valid_width: assert property (remote_on_pulse
        |-> $past(pin_i, 8) == $past(invert, 8) && $past(pin_i, 1000) == $past(invert, 1000))
        else $error("short pulse accepted");
    a_own_blank: assert property ($rose(pin_oe_n) && func_sel == 2'h0 |=> !remote_on_pulse [*8])
        else $error("own pulse taken as request");
endmodule
bind stp_sync_on stp_sync_on_sva u_sva (.clk(clk), .srst(srst), .invert(invert), .func_sel(func_sel),
    .out_src(out_src), .local_on_req(local_on_req), .local_off_req(local_off_req), .out_on(out_on),
    .remote_on_pulse(remote_on_pulse), .in_level(in_level), .pin_i(pin_i), .pin_o(pin_o), .pin_oe_n(pin_oe_n));
`default_nettype wire

// ### verification/stp_far_pin.sv
`timescale 1ns/100ps
`default_nettype none
module stp_far_pin (
    // Clock
    input wire logic clk,
    // Pulse request
    input wire logic invert,
    input wire logic go,
    input wire logic [15:0] len,
    // Pin drive
    output logic drv_n,
    output var logic lvl
);
    logic [15:0] cnt_r = 16'h0000;
    always @(posedge clk) begin
        if (go)
            cnt_r <= len;
        else if (cnt_r != 16'h0000)
            cnt_r <= cnt_r - 16'h0001;
    end
    // Active level for the whole count, released level after
    assign drv_n = (cnt_r == 16'h0000);
    assign lvl = drv_n ? ~invert : invert;
endmodule
`default_nettype wire

// ### verification/sync_turn_on_pin_control_bench.sv
`timescale 1ns/100ps
`default_nettype none
module sync_turn_on_pin_control_bench;
    logic clk = 1'b0, srst = 1'b1, inv = 1'b0, on_req = 1'b0, off_req = 1'b0, go = 1'b0, prev_on = 1'b0;
    logic [1:0] fsel = 2'h0, src = 2'h0;
    logic [15:0] per = stp_pkg::PWM_PERIOD_RST, hi = stp_pkg::PWM_HIGH_RST, len = 16'h0000, seed = 16'h0002;
    logic out_on, rpulse, in_level, pin_o, pin_oe_n, far_n, far_lvl, pin_w;
    logic [1:0] notes[$];
    int num_errors = 0, tests_run = 0, cyc = 0, ones;
    always #12.5 clk = ~clk;
    // Pin rests at the inactive level when nobody drives it
    assign pin_w = !pin_oe_n ? pin_o : (!far_n ? far_lvl : ~inv);
    stp_sync_on u_dut (.clk(clk), .srst(srst), .invert(inv), .func_sel(fsel), .out_src(src), .pwm_period(per),
        .pwm_high(hi), .local_on_req(on_req), .local_off_req(off_req), .out_on(out_on), .remote_on_pulse(rpulse),
        .in_level(in_level), .pin_i(pin_w), .pin_o(pin_o), .pin_oe_n(pin_oe_n));
    stp_far_pin u_far (.clk(clk), .invert(inv), .go(go), .len(len), .drv_n(far_n), .lvl(far_lvl));
    function automatic logic [15:0] xs();
        seed = seed ^ (seed << 7);
        seed = seed ^ (seed >> 9);
        seed = seed ^ (seed << 8);
        return seed;
    endfunction
    task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
        tests_run++;
        if (seen !== exp) begin
            num_errors++;
            $display("[ERR] t=%0t %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic wait_n(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic far_pulse(input int n, input int w);
        len = 16'(n);
        go = 1'b1;
        wait_n(1);
        go = 1'b0;
        wait_n(w);
    endtask
    task automatic req(input logic [1:0] note, input logic on);
        notes.push_back(note);
        if (on)
            on_req = 1'b1;
        else
            off_req = 1'b1;
        wait_n(1);
        if (on)
            on_req = 1'b0;
        else
            off_req = 1'b0;
    endtask
    // ------------------------------------------------------------
    // Result monitor
    // ------------------------------------------------------------
    always @(posedge clk) begin
        #1;
        if (!srst && out_on !== prev_on) begin
            if (notes.size() == 0)
                check(16'(out_on), 16'(prev_on), "unexpected change");
            else
                check(16'({out_on, rpulse}), 16'(notes.pop_front()), "state change");
        end
        prev_on = srst ? 1'b0 : out_on;
        cyc++;
        if (cyc == 40000) begin
            num_errors++;
            print_verdict();
        end
    end
    // ------------------------------------------------------------
    // Stimulus
    // ------------------------------------------------------------
    initial begin
        wait_n(16);
        srst = 1'b0;
        for (int i = 0; i < 2; i++) begin
            inv = i[0];
            wait_n(4);
            req(2'b10, 1'b1);
            check(16'({pin_oe_n, pin_o}), 16'({1'b0, inv}), "emitted pulse");
            req(2'b00, 1'b0);
            wait_n(4000);
            far_pulse(1100, 1400);
            notes.push_back(2'b11);
            far_pulse(1200 + xs() % 200, 1500);
            far_pulse(1300, 1500);
            req(2'b00, 1'b0);
            fsel = 2'h1;
            far_pulse(60, 20);
            check(16'(in_level), 16'h0000, "active level");
            wait_n(60);
            check(16'(in_level), 16'h0001, "idle level");
            fsel = 2'h2;
            for (int s = 0; s < 2; s++) begin
                src = 2'(s);
                wait_n(3);
                check(16'({pin_oe_n, pin_o}), 16'({1'b0, inv ^ (s == 1)}), "constant drive");
            end
            src = 2'h2;
            per = 16'h0010;
            hi = xs() % 16'h000f + 16'h0001;
            wait_n(40);
            ones = 0;
            repeat (64) begin
                @(negedge clk);
                ones += int'(pin_o == inv);
            end
            check(16'(ones), hi << 2, "pwm duty");
            fsel = 2'h0;
            $display("test with invert %0d done", i);
        end
        wait_n(4);
        check(16'(notes.size()), 16'h0000, "notes left");
        print_verdict();
    end
endmodule
`default_nettype wire
